// file: common/capture_pkg.sv
// Constants, register map and types for the capture channel
package capture_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int PRE_SEL_W = 4;

	// Register indices
	localparam logic [2:0] ADDR_POWER = 3'h0;
	localparam logic [2:0] ADDR_PRESCALER = 3'h1;
	localparam logic [2:0] ADDR_MODE = 3'h2;
	localparam logic [2:0] ADDR_TRIGGER = 3'h3;
	localparam logic [2:0] ADDR_ENABLED = 3'h4;
	localparam logic [2:0] ADDR_COUNTER = 3'h5;
	localparam logic [2:0] ADDR_DATA = 3'h6;
	localparam logic [2:0] ADDR_STATUS = 3'h7;

	// Field positions
	localparam int POWER_BIT = 0;
	localparam int START_BIT = 0;
	localparam int STOP_BIT = 1;
	localparam int OVF_BIT = 0;
	localparam int ENABLED_BIT = 0;
	localparam int PRE_A_LSB = 0;
	localparam int PRE_B_LSB = 4;
	localparam int MODE_START_IRQ_BIT = 0;
	localparam int MODE_OP_LSB = 1;
	localparam int MODE_EDGE_LOW_BIT = 6;
	localparam int MODE_EDGE_HIGH_BIT = 7;
	localparam int MODE_TRIG_LSB = 8;
	localparam int MODE_CLK_SEL_BIT = 15;
	localparam logic [15:0] MODE_EDGE_MASK = 16'h00c0;

	// Encodings
	localparam logic [2:0] OP_INTERVAL = 3'h2;
	localparam logic [2:0] OP_WIDTH = 3'h6;
	localparam logic [2:0] TRIG_PIN_EDGE = 3'h1;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] WIDTH_LOW = 2'h2;
	localparam logic [1:0] WIDTH_HIGH = 2'h3;

	// Reset and count values
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] FULL16 = 16'hffff;
	localparam logic [7:0] PRESCALER_RESET = 8'h00;
	localparam logic [15:0] MODE_RESET = 16'h0000;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_INTERVAL = 4'h2,
		ST_WAIT_START = 4'h4,
		ST_MEASURE = 4'h8
	} chan_state_t;
endpackage : capture_pkg

// file: hdl/pin_sampler.sv
// Capture pin synchroniser and operating-clock edge sampler
`timescale 1ns/1ps
module pin_sampler (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic sample_en,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic last;
	} samp_state_t;

	samp_state_t q;
	samp_state_t d;

	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		// Track level while off so no false edge appears on power-up
		if (clear || sample_en) begin
			d.last = q.s2;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Edges seen only at operating-clock ticks
	assign rise = sample_en & ~clear & q.s2 & ~q.last;
	assign fall = sample_en & ~clear & ~q.s2 & q.last;
endmodule : pin_sampler

// file: hdl/capture_channel.sv
// Capture channel with interval and level-width measurement
//
// Operation
// - Interval start sets enable, clears counter next tick, optional start interrupt.
// - Interval edge captures count, clears counter, interrupts, keeps counting.
// - Each capture sets or clears overflow flag from the measured period.
// - Stop clears enable, halts counting, keeps counter and overflow flag.
// - Start and stop are write-one triggers that always read back zero.
// - Power bit low stops clock, ignores writes, resets all channel state.
// - Power bit high supplies clock and accepts writes, channel stays stopped.
// - Width start sets enable and waits for start edge without counting.
// - Width counts after start edge, opposite edge captures and interrupts.
// - After width capture counter holds capture plus one, waits again.
// - Overflow flag updated at capture, set by one or more wraps, does not count them.
// - Edge select picks low width with 10B, high width with 11B.
// - Width start is ignored while the channel is enabled.
// - Pin sampled on the selected operating clock, one period uncertainty.
// - Width equals tick period times overflow times 10000H plus capture plus one.
// - Trigger field 001B makes pin edges the interval capture trigger; only a start write starts the interval.
// - Interval edges: 00B falling, 01B rising, 10B both, 11B none.
// - Interval start write while enabled acts as a software capture.
`timescale 1ns/1ps
module capture_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	input wire logic capture_input_pin,
	output logic channel_interrupt,
	output logic channel_enabled_flag,
	output logic unit_power_enable
);
	typedef struct packed {
		logic power;
		logic [7:0] prescaler;
		logic [15:0] mode;
		logic enabled;
		capture_pkg::chan_state_t state;
		logic [15:0] counter;
		logic [15:0] data;
		logic overflow;
		logic ovf_acc;
		logic clear_pend;
		logic sw_capture;
		logic irq;
		logic [15:0] pre_cnt;
		logic [15:0] rdata;
	} chan_reg_t;

	chan_reg_t q;
	chan_reg_t d;

	logic tick_a;
	logic tick_b;
	logic count_tick;
	logic pin_rise;
	logic pin_fall;
	logic start_wr;
	logic stop_wr;
	logic [2:0] op_mode;
	logic [1:0] edge_sel;
	logic [2:0] trig_sel;
	logic interval_edge;
	logic width_start_edge;
	logic width_capture_edge;

	// Tick when the low n bits of the prescaler counter are all ones
	function automatic logic div_tick(input logic [15:0] cnt, input logic [3:0] sel);
		logic [15:0] mask;
		mask = 16'(({1'b0, capture_pkg::ONE16} << sel) - 17'h00001);
		div_tick = ((cnt & mask) == mask);
	endfunction : div_tick

	// Interval-mode valid edge decode
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = 1'b0;
		if (sel == capture_pkg::EDGE_FALL) begin
			edge_hit = f;
		end else if (sel == capture_pkg::EDGE_RISE) begin
			edge_hit = r;
		end else if (sel == capture_pkg::EDGE_BOTH) begin
			edge_hit = r | f;
		end
	endfunction : edge_hit

	assign tick_a = q.power & div_tick(q.pre_cnt, q.prescaler[capture_pkg::PRE_A_LSB +: 4]);
	assign tick_b = q.power & div_tick(q.pre_cnt, q.prescaler[capture_pkg::PRE_B_LSB +: 4]);
	assign count_tick = q.mode[capture_pkg::MODE_CLK_SEL_BIT] ? tick_b : tick_a;

	pin_sampler u_sampler (
		.clk(clk),
		.rst_n(rst_n),
		.clear(~q.power),
		.sample_en(count_tick),
		.pin(capture_input_pin),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	assign op_mode = q.mode[capture_pkg::MODE_OP_LSB +: 3];
	assign edge_sel = {q.mode[capture_pkg::MODE_EDGE_HIGH_BIT],
		q.mode[capture_pkg::MODE_EDGE_LOW_BIT]};
	assign trig_sel = q.mode[capture_pkg::MODE_TRIG_LSB +: 3];
	assign interval_edge = (trig_sel == capture_pkg::TRIG_PIN_EDGE) &&
		edge_hit(edge_sel, pin_rise, pin_fall);
	assign width_start_edge = (edge_sel == capture_pkg::WIDTH_HIGH) ? pin_rise : pin_fall;
	assign width_capture_edge = (edge_sel == capture_pkg::WIDTH_HIGH) ? pin_fall : pin_rise;

	// Writes other than to the power bit are ignored while off
	assign start_wr = q.power && wr_en && (addr == capture_pkg::ADDR_TRIGGER) &&
		wdata[capture_pkg::START_BIT];
	assign stop_wr = q.power && wr_en && (addr == capture_pkg::ADDR_TRIGGER) &&
		wdata[capture_pkg::STOP_BIT];

	always_comb begin
		d = q;
		d.irq = 1'b0;
		d.pre_cnt = q.power ? 16'(q.pre_cnt + capture_pkg::ONE16) : capture_pkg::ZERO16;

		// Configuration writes
		if (q.power && wr_en && addr == capture_pkg::ADDR_PRESCALER) begin
			d.prescaler = wdata[7:0];
		end else if (q.power && wr_en && addr == capture_pkg::ADDR_MODE) begin
			if (q.enabled) begin
				d.mode = (q.mode & ~capture_pkg::MODE_EDGE_MASK) |
					(wdata & capture_pkg::MODE_EDGE_MASK);
			end else begin
				d.mode = wdata;
			end
		end

		// Counting
		case (q.state)
			capture_pkg::ST_INTERVAL: begin
				if (count_tick) begin
					if (q.clear_pend) begin
						d.counter = capture_pkg::ZERO16;
						d.ovf_acc = 1'b0;
						d.clear_pend = 1'b0;
					end else if (interval_edge || q.sw_capture) begin
						d.data = q.counter;
						d.counter = capture_pkg::ZERO16;
						d.overflow = q.ovf_acc;
						d.ovf_acc = 1'b0;
						d.sw_capture = 1'b0;
						d.irq = 1'b1;
					end else begin
						d.counter = 16'(q.counter + capture_pkg::ONE16);
						if (q.counter == capture_pkg::FULL16) begin
							d.ovf_acc = 1'b1;
						end
					end
				end
			end
			capture_pkg::ST_WAIT_START: begin
				if (count_tick && width_start_edge) begin
					d.counter = capture_pkg::ZERO16;
					d.ovf_acc = 1'b0;
					d.state = capture_pkg::ST_MEASURE;
				end
			end
			capture_pkg::ST_MEASURE: begin
				if (count_tick) begin
					d.counter = 16'(q.counter + capture_pkg::ONE16);
					if (width_capture_edge) begin
						d.data = q.counter;
						d.overflow = q.ovf_acc;
						d.ovf_acc = 1'b0;
						d.irq = 1'b1;
						d.state = capture_pkg::ST_WAIT_START;
					end else if (q.counter == capture_pkg::FULL16) begin
						d.ovf_acc = 1'b1;
					end
				end
			end
			default: begin
				d.state = capture_pkg::ST_IDLE;
			end
		endcase

		// Start trigger
		if (start_wr && !stop_wr) begin
			if (op_mode == capture_pkg::OP_WIDTH) begin
				if (!q.enabled) begin
					d.enabled = 1'b1;
					d.state = capture_pkg::ST_WAIT_START;
				end
			end else if (q.enabled) begin
				if (q.state == capture_pkg::ST_INTERVAL) begin
					d.sw_capture = 1'b1;
				end
			end else begin
				d.enabled = 1'b1;
				if (op_mode == capture_pkg::OP_INTERVAL) begin
					d.state = capture_pkg::ST_INTERVAL;
					d.clear_pend = 1'b1;
					d.sw_capture = 1'b0;
					d.irq = q.mode[capture_pkg::MODE_START_IRQ_BIT];
				end
			end
		end

		// Stop trigger holds counter and overflow flag
		if (stop_wr) begin
			d.enabled = 1'b0;
			d.state = capture_pkg::ST_IDLE;
			d.clear_pend = 1'b0;
			d.sw_capture = 1'b0;
		end

		// Register read, data in the next cycle
		d.rdata = capture_pkg::ZERO16;
		if (rd_en) begin
			if (addr == capture_pkg::ADDR_POWER) begin
				d.rdata[capture_pkg::POWER_BIT] = q.power;
			end else if (addr == capture_pkg::ADDR_PRESCALER) begin
				d.rdata[7:0] = q.prescaler;
			end else if (addr == capture_pkg::ADDR_MODE) begin
				d.rdata = q.mode;
			end else if (addr == capture_pkg::ADDR_ENABLED) begin
				d.rdata[capture_pkg::ENABLED_BIT] = q.enabled;
			end else if (addr == capture_pkg::ADDR_COUNTER) begin
				d.rdata = q.counter;
			end else if (addr == capture_pkg::ADDR_DATA) begin
				d.rdata = q.data;
			end else if (addr == capture_pkg::ADDR_STATUS) begin
				d.rdata[capture_pkg::OVF_BIT] = q.overflow;
			end
		end

		// Power bit; clearing it resets the whole channel
		if (wr_en && addr == capture_pkg::ADDR_POWER) begin
			d.power = wdata[capture_pkg::POWER_BIT];
			if (!wdata[capture_pkg::POWER_BIT]) begin
				d.prescaler = capture_pkg::PRESCALER_RESET;
				d.mode = capture_pkg::MODE_RESET;
				d.enabled = 1'b0;
				d.state = capture_pkg::ST_IDLE;
				d.counter = capture_pkg::ZERO16;
				d.data = capture_pkg::ZERO16;
				d.overflow = 1'b0;
				d.ovf_acc = 1'b0;
				d.clear_pend = 1'b0;
				d.sw_capture = 1'b0;
				d.irq = 1'b0;
				d.pre_cnt = capture_pkg::ZERO16;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q.power <= 1'b0;
			q.prescaler <= capture_pkg::PRESCALER_RESET;
			q.mode <= capture_pkg::MODE_RESET;
			q.enabled <= 1'b0;
			q.state <= capture_pkg::ST_IDLE;
			q.counter <= capture_pkg::ZERO16;
			q.data <= capture_pkg::ZERO16;
			q.overflow <= 1'b0;
			q.ovf_acc <= 1'b0;
			q.clear_pend <= 1'b0;
			q.sw_capture <= 1'b0;
			q.irq <= 1'b0;
			q.pre_cnt <= capture_pkg::ZERO16;
			q.rdata <= capture_pkg::ZERO16;
		end else begin
			q <= d;
		end
	end

	// Trigger register reads as zero
	assign rdata = q.rdata;
	assign channel_interrupt = q.irq;
	assign channel_enabled_flag = q.enabled;
	assign unit_power_enable = q.power;
endmodule : capture_channel

// file: dv/capture_channel_asserts.sv
// Port checker for the capture channel
`timescale 1ns/1ps
module capture_channel_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] rdata,
	input wire logic capture_input_pin,
	input wire logic channel_interrupt,
	input wire logic channel_enabled_flag,
	input wire logic unit_power_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence trig_wr(b);
		wr_en && addr == capture_pkg::ADDR_TRIGGER && wdata[b];
	endsequence
	sequence pwr_wr(v);
		wr_en && addr == capture_pkg::ADDR_POWER && wdata[capture_pkg::POWER_BIT] == v;
	endsequence
	idle_rdata_a: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data not zero when idle");
	trig_read_a: assert property (rd_en && addr == capture_pkg::ADDR_TRIGGER |=> rdata == 16'h0000)
		else $error("trigger read not zero");
	enab_read_a: assert property (rd_en && addr == capture_pkg::ADDR_ENABLED
		|=> rdata == {15'h0000, $past(channel_enabled_flag)})
		else $error("enable readback wrong");
	stop_clears_a: assert property (trig_wr(capture_pkg::STOP_BIT) |=> !channel_enabled_flag)
		else $error("stop did not clear enable");
	start_sets_a: assert property (trig_wr(capture_pkg::START_BIT) && !wdata[capture_pkg::STOP_BIT]
		&& unit_power_enable && !channel_enabled_flag |=> channel_enabled_flag)
		else $error("start did not set enable");
	enab_cause_a: assert property ($rose(channel_enabled_flag) |-> $past(wr_en
		&& addr == capture_pkg::ADDR_TRIGGER && wdata[capture_pkg::START_BIT]))
		else $error("enable rose without start");
	power_gate_a: assert property (!unit_power_enable |=> !channel_enabled_flag)
		else $error("enabled while unpowered");
	power_on_a: assert property (pwr_wr(1'b1) && !unit_power_enable
		|=> unit_power_enable && !channel_enabled_flag)
		else $error("power on wrong");
	power_off_a: assert property (pwr_wr(1'b0) |=> !unit_power_enable ##1 !channel_enabled_flag)
		else $error("power off wrong");
	status_read_a: assert property (rd_en && addr == capture_pkg::ADDR_STATUS
		|=> rdata[15:1] == 15'h0000)
		else $error("status upper bits set");
endmodule : capture_channel_asserts

bind capture_channel capture_channel_asserts i_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
	.capture_input_pin(capture_input_pin), .channel_interrupt(channel_interrupt),
	.channel_enabled_flag(channel_enabled_flag), .unit_power_enable(unit_power_enable));

// file: dv/pulse_source.sv
// External pulse source on the capture pin
`timescale 1ns/1ps
module pulse_source (
	input wire logic clk,
	input wire logic level_req,
	output logic pin
);
	initial pin = 1'b0;
	always @(posedge clk) begin
		pin <= level_req;
	end
endmodule : pulse_source

// file: dv/capture_interval_width_channel_bench.sv
// Self-checking bench for the capture channel
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module capture_interval_width_channel_bench;
	logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, want = 0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000, rdata, rv;
	logic pin, irq, enab, pwr;
	int fails = 0, num_checks = 0, cyc = 0, n, t, pg, w;
	logic [1:0] modes [3] = '{capture_pkg::EDGE_FALL, capture_pkg::EDGE_BOTH, capture_pkg::EDGE_RISE};
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	capture_channel i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .capture_input_pin(pin), .channel_interrupt(irq),
		.channel_enabled_flag(enab), .unit_power_enable(pwr));
	pulse_source i_src (.clk(clk), .level_req(want), .pin(pin));
	task give_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
		@(posedge clk) wr_en <= 1'b0;
		#1;
	endtask : wr
	task chk_rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk) begin addr <= a; rd_en <= 1'b1; end
		@(posedge clk) rd_en <= 1'b0;
		#1 rv = rdata;
		`CHK(rv, e)
	endtask : chk_rd
	task wait_irq;
		int k;
		for (k = 0; k < 20 && irq !== 1'b1; k++) begin @(posedge clk); #1; end
		`CHK(irq, 1'b1)
		if (k == 20) give_verdict();
	endtask : wait_irq
	task wait_until(input int c);
		while (cyc < c) begin @(posedge clk); #1; end
	endtask : wait_until
	function automatic logic [15:0] mw(input logic [2:0] op, input logic [1:0] e, input logic s);
		return (16'(capture_pkg::TRIG_PIN_EDGE) << capture_pkg::MODE_TRIG_LSB)
			| (16'(op) << capture_pkg::MODE_OP_LSB)
			| (16'(e) << capture_pkg::MODE_EDGE_LOW_BIT) | 16'(s);
	endfunction : mw
	// Mode written only while stopped
	task setup(input logic [2:0] op, input logic [1:0] e, input logic pre, input logic s);
		wr(capture_pkg::ADDR_TRIGGER, 16'h0002);
		wr(capture_pkg::ADDR_MODE, mw(op, e, s));
		want <= pre;
		repeat (8) @(posedge clk);
		wr(capture_pkg::ADDR_TRIGGER, 16'h0001);
		if (s) wait_irq();
	endtask : setup
	task ev(input logic [1:0] e, input int gap, input logic cd, input logic [15:0] ed,
		input logic [15:0] ov);
		t = cyc;
		if (e == capture_pkg::EDGE_BOTH) want <= ~want;
		else want <= (e == capture_pkg::EDGE_RISE);
		wait_irq();
		if (cd) chk_rd(capture_pkg::ADDR_DATA, ed);
		chk_rd(capture_pkg::ADDR_STATUS, ov);
		wait_until(t + gap / 2);
		if (e != capture_pkg::EDGE_BOTH) want <= (e != capture_pkg::EDGE_RISE);
		wait_until(t + gap);
	endtask : ev
	initial begin
		n = $urandom(56824);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1 `CHK({irq, enab, pwr}, 3'h0)
		wr(capture_pkg::ADDR_TRIGGER, 16'h0001);
		`CHK(enab, 1'b0)
		wr(capture_pkg::ADDR_POWER, 16'h0001);
		wr(capture_pkg::ADDR_PRESCALER, 16'h0000);
		`CHK({pwr, enab}, 2'h2)
		for (int m = 0; m < 3; m++) begin
			setup(capture_pkg::OP_INTERVAL, modes[m], modes[m] != capture_pkg::EDGE_RISE, 1'b1);
			for (int i = 0; i < 4; i++) begin
				w = $urandom_range(60, 30);
				ev(modes[m], w, i > 0, 16'(pg - 1), 16'h0000);
				pg = w;
			end
		end
		ev(capture_pkg::EDGE_RISE, 65600, 1'b1, 16'(pg - 1), 16'h0000);
		ev(capture_pkg::EDGE_RISE, 30, 1'b1, 16'h003f, 16'h0001);
		ev(capture_pkg::EDGE_RISE, 30, 1'b1, 16'h001d, 16'h0000);
		wr(capture_pkg::ADDR_TRIGGER, 16'h0001);
		wait_irq();
		wr(capture_pkg::ADDR_TRIGGER, 16'h0002);
		`CHK(enab, 1'b0)
		chk_rd(capture_pkg::ADDR_COUNTER, 16'h0002);
		repeat (5) @(posedge clk);
		chk_rd(capture_pkg::ADDR_COUNTER, rv);
		chk_rd(capture_pkg::ADDR_TRIGGER, 16'h0000);
		wr(capture_pkg::ADDR_POWER, 16'h0000);
		wr(capture_pkg::ADDR_POWER, 16'h0001);
		for (int a = 5; a < 8; a++) chk_rd(3'(a), 16'h0000);
		for (int m = 0; m < 2; m++) begin
			setup(capture_pkg::OP_WIDTH, m ? capture_pkg::WIDTH_LOW : capture_pkg::WIDTH_HIGH,
				m[0], 1'b0);
			chk_rd(capture_pkg::ADDR_COUNTER, m ? 16'(w) : 16'h0000);
			repeat (10) @(posedge clk);
			chk_rd(capture_pkg::ADDR_COUNTER, rv);
			w = $urandom_range(40, 10);
			t = cyc;
			want <= ~m[0];
			wait_until(t + w);
			want <= m[0];
			wait_irq();
			chk_rd(capture_pkg::ADDR_DATA, 16'(w - 1));
			chk_rd(capture_pkg::ADDR_COUNTER, 16'(w));
		end
		give_verdict();
	end
endmodule : capture_interval_width_channel_bench
